// File: rtl/mdil_pkg.sv
// Shared constants and types for the monitor DMA interrupt logger.
// Overview of operation
// - Each monitored data word is DMA-written sequentially.
// - Received monitor status word is DMA-written to block.
// - High-priority output follows enable; errors hold until acknowledged.
// - Log burst: status, pointer, tail read, then pulse.
// - Message end burst writes control word, fetches tail.
// - Log entry is three words, tail host-initialised.
// - Only enabled interrupt types create log entries.
// - Host seeds log pointer; device advances it.
// - Writing one clears high-priority cause, dropping output.
// - Standard level holds until its status bit clears.
// - One standard pulse per enabled event occurrence.
// - Status word bit 15 always set when written.
// - Bit 14 marks response time-out; bits active high.
// - Terminal bit 13 returned message error; 12-8 reserved.
// - Terminal bit 7 marks descriptor interrupt access.
// - Terminal bit 6 marks mode code without data.
// - Terminal bit 5 marks illegal broadcast receive.
// - Terminal bit 4 marks illegal command.
// - Controller bits 3 poll match, 2 retries failed.
// - Bit 1 message error, bit 0 interrupt-and-continue.
// - Block activated flag set whenever block accessed.
package mdil_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    localparam int IDX_W = 5;
    localparam logic [IDX_W-1:0] REG_MON_BLOCK = 5'h05;
    localparam logic [IDX_W-1:0] REG_LOG_PTR = 5'h06;
    localparam logic [IDX_W-1:0] REG_HP_ENABLE = 5'h07;
    localparam logic [IDX_W-1:0] REG_HP_STATUS = 5'h08;
    localparam logic [IDX_W-1:0] REG_STD_ENABLE = 5'h09;
    localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
    localparam int HP_STD_BIT = 0;
    localparam int HP_ME_BIT = 1;
    localparam logic [DATA_W-1:0] HP_ONLY_MASK = 16'hfffe;
    localparam int ISW_ACCESSED = 15;
    localparam int ISW_TIMEOUT = 14;
    localparam int ISW_RT_ME = 13;
    localparam int ISW_SA_EVENT = 7;
    localparam int ISW_MC_NODATA = 6;
    localparam int ISW_ILL_BCAST = 5;
    localparam int ISW_ILL_CMD = 4;
    localparam int ISW_POLL = 3;
    localparam int ISW_RETRY = 2;
    localparam int ISW_MSG_ERR = 1;
    localparam int ISW_IRQ_CONT = 0;
    localparam logic [DATA_W-1:0] ISW_RSV_MASK = 16'h1f00;
    localparam logic [DATA_W-1:0] MASK_BC = 16'h400f;
    localparam logic [DATA_W-1:0] MASK_RT = 16'h60f2;
    localparam logic [DATA_W-1:0] MASK_MON = 16'h4002;
    localparam int CBA_BIT = 15;
    localparam logic [ADDR_W-1:0] MCB_CTRL = 16'h0000;
    localparam logic [ADDR_W-1:0] MCB_STAT1 = 16'h0004;
    localparam logic [ADDR_W-1:0] MCB_STAT2 = 16'h0005;
    localparam logic [ADDR_W-1:0] MCB_TAIL = 16'h0006;
    localparam logic [ADDR_W-1:0] LOG_OFS_PTR = 16'h0001;
    localparam logic [ADDR_W-1:0] LOG_OFS_TAIL = 16'h0002;
    localparam logic [1:0] LOG_LAST_STEP = 2'h2;
    localparam logic [1:0] DONE_LAST_STEP = 2'h1;
    localparam int FIFO_WORDS = 16;
    localparam int HOST_MEM_WORDS = 256;
    typedef enum logic [1:0] {MDIL_MODE_BC, MDIL_MODE_RT, MDIL_MODE_MON} mdil_mode_type;
    typedef enum logic [2:0] {JOB_NONE, JOB_LOG, JOB_DONE, JOB_STAT, JOB_DATA} mdil_job_type;
    typedef enum logic [1:0] {ST_IDLE, ST_ARB, ST_XFER} mdil_state_type;
endpackage

// File: rtl/mdil_link_if.sv
// Link between the logger device end and the host end: DMA, registers and interrupts.
`timescale 1ns/1ps
`default_nettype none
interface mdil_link_if;
    import mdil_pkg::*;
    logic dma_req;
    logic dma_burst;
    logic dma_grant;
    logic mem_strobe;
    logic mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] mem_wdata;
    logic [DATA_W-1:0] mem_rdata;
    logic mem_ack;
    logic reg_wr;
    logic reg_rd;
    logic [IDX_W-1:0] reg_idx;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic high_priority_irq;
    logic std_irq_level;
    logic std_irq_pulse_b;
    modport device (
        output dma_req, dma_burst, mem_strobe, mem_we, mem_addr, mem_wdata, reg_rdata,
        output high_priority_irq, std_irq_level, std_irq_pulse_b,
        input dma_grant, mem_rdata, mem_ack, reg_wr, reg_rd, reg_idx, reg_wdata
    );
    modport host (
        input dma_req, dma_burst, mem_strobe, mem_we, mem_addr, mem_wdata, reg_rdata,
        input high_priority_irq, std_irq_level, std_irq_pulse_b,
        output dma_grant, mem_rdata, mem_ack, reg_wr, reg_rd, reg_idx, reg_wdata
    );
endinterface
`default_nettype wire

// File: rtl/mdil_fifo.sv
// Synchronous word FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module mdil_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic mclk, // Memory clock.
    input wire logic rst_b, // Synchronous reset, active low.
    input wire logic in_valid, // Write side offers a word.
    output logic in_ready, // Room for a word.
    input wire logic [WIDTH-1:0] in_data, // Word written.
    output logic out_valid, // Head word present.
    input wire logic out_ready, // Drain side takes the head.
    output logic [WIDTH-1:0] out_data // Head word.
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
        logic not_full;
        logic not_empty;
    } mdil_fifo_type;
    mdil_fifo_type s;
    mdil_fifo_type next_s;
    logic push;
    logic pop;

    always_comb begin
        push = in_valid && s.not_full;
        pop = out_ready && s.not_empty;
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = (s.wp == PW'(DEPTH - 1)) ? '0 : PW'(s.wp + 1'b1);
        end
        if (pop) begin
            next_s.rp = (s.rp == PW'(DEPTH - 1)) ? '0 : PW'(s.rp + 1'b1);
        end
        if (push && !pop) begin
            next_s.cnt = (PW + 1)'(s.cnt + 1'b1);
        end else if (pop && !push) begin
            next_s.cnt = (PW + 1)'(s.cnt - 1'b1);
        end
        next_s.not_full = next_s.cnt != (PW + 1)'(DEPTH);
        next_s.not_empty = next_s.cnt != '0;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s <= '0;
            s.not_full <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign in_ready = s.not_full;
    assign out_valid = s.not_empty;
    assign out_data = s.mem[s.rp];
endmodule
`default_nettype wire

// File: rtl/mdil_device_end.sv
// Device end: monitor DMA sequencing, interrupt logging and interrupt outputs.
`timescale 1ns/1ps
`default_nettype none
module mdil_device_end #(
    parameter int FIFO_DEPTH = mdil_pkg::FIFO_WORDS
) (
    input wire logic mclk, // Memory clock, 40 MHz.
    input wire logic rst_b, // Synchronous reset, active low.
    mdil_link_if.device link, // DMA, register and interrupt link.
    input wire mdil_pkg::mdil_mode_type mode, // Operating mode.
    input wire logic evt_valid, // Interrupt event offered.
    input wire logic [mdil_pkg::DATA_W-1:0] evt_cause, // Raw status word cause bits.
    input wire logic [mdil_pkg::ADDR_W-1:0] evt_ptr, // Command block or descriptor pointer.
    output logic evt_ready, // Event can be taken.
    input wire logic mon_dlp_load, // Load data list pointer.
    input wire logic [mdil_pkg::ADDR_W-1:0] mon_dlp, // Data list pointer.
    input wire logic mon_data_valid, // Monitored data word offered.
    input wire logic [mdil_pkg::DATA_W-1:0] mon_data, // Monitored data word.
    output logic mon_data_ready, // Data buffer has room.
    input wire logic mon_stat_valid, // Monitored status word offered.
    input wire logic mon_stat_sel, // Zero first status slot, one second.
    input wire logic [mdil_pkg::DATA_W-1:0] mon_stat, // Status word.
    output logic mon_stat_ready, // Status word can be taken.
    input wire logic mon_done_valid, // Message complete.
    input wire logic [mdil_pkg::DATA_W-1:0] mon_ctrl, // Control/status word to store.
    output logic mon_done_ready, // Completion can be taken.
    output logic hold // Held on an unacknowledged message error.
);
    import mdil_pkg::*;
    typedef struct packed {
        mdil_state_type st;
        mdil_job_type job;
        logic [1:0] step;
        logic req;
        logic strobe;
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [ADDR_W-1:0] log_ptr;
        logic [ADDR_W-1:0] mon_blk;
        logic [DATA_W-1:0] hp_en;
        logic [DATA_W-1:0] hp_stat;
        logic [DATA_W-1:0] std_en;
        logic [ADDR_W-1:0] data_ptr;
        logic log_pend;
        logic [DATA_W-1:0] log_isw;
        logic [ADDR_W-1:0] log_word;
        logic stat_pend;
        logic stat_sel;
        logic [DATA_W-1:0] stat_word;
        logic done_pend;
        logic [DATA_W-1:0] done_ctrl;
        logic pulse_b;
        logic level;
        logic hpirq;
        logic [DATA_W-1:0] rdata;
        logic evt_rdy;
        logic stat_rdy;
        logic done_rdy;
        logic hold;
    } mdil_dev_type;
    mdil_dev_type s;
    mdil_dev_type next_s;
    logic fifo_valid;
    logic fifo_pop;
    logic [DATA_W-1:0] fifo_data;
    logic [DATA_W-1:0] mode_mask;
    logic [DATA_W-1:0] logged;
    logic last;
    logic [DATA_W-1:0] clr;

    // Data words are buffered so the bus side waits on DMA arbitration only when the FIFO is full.
    mdil_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_data_fifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_valid(mon_data_valid),
        .in_ready(mon_data_ready),
        .in_data(mon_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // Issues word number step of job j onto the memory link.
    function automatic mdil_dev_type issue(input mdil_dev_type c, input mdil_job_type j,
                                           input logic [1:0] k, input logic [DATA_W-1:0] fd);
        mdil_dev_type r;
        r = c;
        r.job = j;
        r.step = k;
        r.strobe = 1'b1;
        r.we = 1'b1;
        r.addr = c.data_ptr;
        r.wdata = fd;
        case (j)
            JOB_LOG: begin
                // Entry: status word, pointer word, then host tail pointer.
                if (k == 2'h0) begin
                    r.addr = c.log_ptr;
                    r.wdata = c.log_isw | (16'h0001 << ISW_ACCESSED);
                end else if (k == 2'h1) begin
                    r.addr = 16'(c.log_ptr + LOG_OFS_PTR);
                    r.wdata = c.log_word;
                end else begin
                    r.addr = 16'(c.log_ptr + LOG_OFS_TAIL);
                    r.we = 1'b0;
                end
            end
            JOB_DONE: begin
                if (k == 2'h0) begin
                    r.addr = 16'(c.mon_blk + MCB_CTRL);
                    r.wdata = c.done_ctrl | (16'h0001 << CBA_BIT);
                end else begin
                    r.addr = 16'(c.mon_blk + MCB_TAIL);
                    r.we = 1'b0;
                end
            end
            JOB_STAT: begin
                r.addr = 16'(c.mon_blk + (c.stat_sel ? MCB_STAT2 : MCB_STAT1));
                r.wdata = c.stat_word;
            end
            default: begin
            end
        endcase
        return r;
    endfunction

    always_comb begin
        next_s = s;
        fifo_pop = 1'b0;
        clr = '0;
        next_s.pulse_b = 1'b1;
        case (mode)
            MDIL_MODE_BC: mode_mask = MASK_BC;
            MDIL_MODE_RT: mode_mask = MASK_RT;
            default: mode_mask = MASK_MON;
        endcase
        // Only cause bits valid in the mode and enabled for logging survive.
        logged = evt_cause & mode_mask & s.std_en & ~ISW_RSV_MASK;
        last = (s.job == JOB_LOG) ? (s.step == LOG_LAST_STEP) :
               (s.job == JOB_DONE) ? (s.step == DONE_LAST_STEP) : 1'b1;

        if (link.reg_wr) begin
            case (link.reg_idx)
                REG_MON_BLOCK: next_s.mon_blk = link.reg_wdata;
                REG_LOG_PTR: next_s.log_ptr = link.reg_wdata;
                REG_HP_ENABLE: next_s.hp_en = link.reg_wdata;
                REG_HP_STATUS: clr = link.reg_wdata;
                REG_STD_ENABLE: next_s.std_en = link.reg_wdata;
                default: begin
                end
            endcase
        end
        if (link.reg_rd) begin
            case (link.reg_idx)
                REG_MON_BLOCK: next_s.rdata = s.mon_blk;
                REG_LOG_PTR: next_s.rdata = s.log_ptr;
                REG_HP_ENABLE: next_s.rdata = s.hp_en;
                REG_HP_STATUS: next_s.rdata = s.hp_stat;
                REG_STD_ENABLE: next_s.rdata = s.std_en;
                default: next_s.rdata = '0;
            endcase
        end
        next_s.hp_stat = s.hp_stat & ~clr;

        if (mon_dlp_load) begin
            next_s.data_ptr = mon_dlp;
        end
        if (evt_valid && s.evt_rdy) begin
            if (logged != '0) begin
                next_s.log_pend = 1'b1;
                next_s.log_isw = logged;
                next_s.log_word = evt_ptr;
            end
            // A set arriving with its clear wins.
            if (evt_cause[ISW_MSG_ERR] && s.hp_en[HP_ME_BIT]) begin
                next_s.hp_stat[HP_ME_BIT] = 1'b1;
            end
        end
        if (mon_stat_valid && s.stat_rdy) begin
            next_s.stat_pend = 1'b1;
            next_s.stat_sel = mon_stat_sel;
            next_s.stat_word = mon_stat;
        end
        if (mon_done_valid && s.done_rdy) begin
            next_s.done_pend = 1'b1;
            next_s.done_ctrl = mon_ctrl;
        end

        case (s.st)
            ST_IDLE: begin
                // Logging first; while held only logging may proceed.
                if (s.log_pend) begin
                    next_s.job = JOB_LOG;
                end else if (s.hold) begin
                    next_s.job = JOB_NONE;
                end else if (s.stat_pend) begin
                    next_s.job = JOB_STAT;
                end else if (fifo_valid) begin
                    next_s.job = JOB_DATA;
                end else if (s.done_pend) begin
                    next_s.job = JOB_DONE;
                end else begin
                    next_s.job = JOB_NONE;
                end
                if (next_s.job != JOB_NONE) begin
                    next_s.req = 1'b1;
                    next_s.st = ST_ARB;
                end
            end
            ST_ARB: begin
                if (link.dma_grant) begin
                    next_s = issue(next_s, s.job, 2'h0, fifo_data);
                    next_s.st = ST_XFER;
                end
            end
            ST_XFER: begin
                if (link.mem_ack) begin
                    next_s.strobe = 1'b0;
                    if (s.job == JOB_LOG && !s.we) begin
                        next_s.log_ptr = link.mem_rdata;
                    end
                    if (s.job == JOB_DONE && !s.we) begin
                        next_s.mon_blk = link.mem_rdata;
                    end
                    if (s.job == JOB_DATA) begin
                        fifo_pop = 1'b1;
                        next_s.data_ptr = 16'(s.data_ptr + 16'h0001);
                    end
                    if (last) begin
                        next_s.req = 1'b0;
                        next_s.st = ST_IDLE;
                        case (s.job)
                            JOB_LOG: begin
                                next_s.log_pend = 1'b0;
                                next_s.pulse_b = 1'b0;
                                next_s.hp_stat[HP_STD_BIT] = 1'b1;
                            end
                            JOB_STAT: next_s.stat_pend = 1'b0;
                            JOB_DONE: next_s.done_pend = 1'b0;
                            default: begin
                            end
                        endcase
                    end else begin
                        next_s = issue(next_s, s.job, 2'(s.step + 1'b1), fifo_data);
                    end
                end
            end
            default: next_s.st = ST_IDLE;
        endcase

        next_s.evt_rdy = !next_s.log_pend;
        next_s.stat_rdy = !next_s.stat_pend;
        next_s.done_rdy = !next_s.done_pend;
        next_s.hold = next_s.hp_stat[HP_ME_BIT];
        next_s.level = next_s.hp_stat[HP_STD_BIT] && next_s.hp_en[HP_STD_BIT];
        next_s.hpirq = |(next_s.hp_stat & next_s.hp_en & HP_ONLY_MASK);
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s <= '0;
            s.st <= ST_IDLE;
            s.job <= JOB_NONE;
            s.hp_en <= REG_RESET;
            s.std_en <= REG_RESET;
            s.pulse_b <= 1'b1;
            s.evt_rdy <= 1'b1;
            s.stat_rdy <= 1'b1;
            s.done_rdy <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign link.dma_req = s.req;
    assign link.dma_burst = s.req && (s.job == JOB_LOG || s.job == JOB_DONE);
    assign link.mem_strobe = s.strobe;
    assign link.mem_we = s.we;
    assign link.mem_addr = s.addr;
    assign link.mem_wdata = s.wdata;
    assign link.reg_rdata = s.rdata;
    assign link.high_priority_irq = s.hpirq;
    assign link.std_irq_level = s.level;
    assign link.std_irq_pulse_b = s.pulse_b;
    assign evt_ready = s.evt_rdy;
    assign mon_stat_ready = s.stat_rdy;
    assign mon_done_ready = s.done_rdy;
    assign hold = s.hold;
endmodule
`default_nettype wire

// File: rtl/mdil_host_end.sv
// Host end: system memory answering DMA, and CPU register and memory access.
`timescale 1ns/1ps
`default_nettype none
module mdil_host_end #(
    parameter int MEM_WORDS = mdil_pkg::HOST_MEM_WORDS
) (
    input wire logic mclk, // Memory clock, 40 MHz.
    input wire logic rst_b, // Synchronous reset, active low.
    mdil_link_if.host link, // DMA, register and interrupt link.
    input wire logic cpu_reg_wr, // Register write request.
    input wire logic cpu_reg_rd, // Register read request.
    input wire logic [mdil_pkg::IDX_W-1:0] cpu_reg_idx, // Register index.
    input wire logic [mdil_pkg::DATA_W-1:0] cpu_reg_wdata, // Register write data.
    output logic [mdil_pkg::DATA_W-1:0] cpu_reg_rdata, // Register read data.
    input wire logic cpu_mem_wr, // Memory write.
    input wire logic [mdil_pkg::ADDR_W-1:0] cpu_mem_addr, // Memory address.
    input wire logic [mdil_pkg::DATA_W-1:0] cpu_mem_wdata, // Memory write data.
    output logic [mdil_pkg::DATA_W-1:0] cpu_mem_rdata, // Memory read data.
    output logic hp_irq, // High-priority interrupt seen.
    output logic std_level, // Standard level interrupt seen.
    output logic std_pulse_b // Standard pulse seen, active low.
);
    import mdil_pkg::*;
    localparam int AW = $clog2(MEM_WORDS);
    typedef struct packed {
        logic [MEM_WORDS-1:0][DATA_W-1:0] mem;
        logic grant;
        logic ack;
        logic [DATA_W-1:0] rdata;
        logic reg_wr;
        logic reg_rd;
        logic [IDX_W-1:0] reg_idx;
        logic [DATA_W-1:0] reg_wdata;
        logic [DATA_W-1:0] reg_rdata;
        logic [DATA_W-1:0] mem_rdata;
        logic hp;
        logic lvl;
        logic pls_b;
    } mdil_host_type;
    mdil_host_type s;
    mdil_host_type next_s;
    logic dma_access;

    always_comb begin
        next_s = s;
        dma_access = link.mem_strobe && s.grant && !s.ack;
        next_s.grant = link.dma_req;
        next_s.ack = dma_access;
        if (dma_access) begin
            if (link.mem_we) begin
                next_s.mem[link.mem_addr[AW-1:0]] = link.mem_wdata;
            end else begin
                next_s.rdata = s.mem[link.mem_addr[AW-1:0]];
            end
        end else if (cpu_mem_wr) begin
            // DMA wins a clash; the host initialises tail pointers here.
            next_s.mem[cpu_mem_addr[AW-1:0]] = cpu_mem_wdata;
        end
        next_s.mem_rdata = s.mem[cpu_mem_addr[AW-1:0]];
        next_s.reg_wr = cpu_reg_wr;
        next_s.reg_rd = cpu_reg_rd;
        next_s.reg_idx = cpu_reg_idx;
        next_s.reg_wdata = cpu_reg_wdata;
        next_s.reg_rdata = link.reg_rdata;
        next_s.hp = link.high_priority_irq;
        next_s.lvl = link.std_irq_level;
        next_s.pls_b = link.std_irq_pulse_b;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s <= '0;
            s.pls_b <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign link.dma_grant = s.grant;
    assign link.mem_ack = s.ack;
    assign link.mem_rdata = s.rdata;
    assign link.reg_wr = s.reg_wr;
    assign link.reg_rd = s.reg_rd;
    assign link.reg_idx = s.reg_idx;
    assign link.reg_wdata = s.reg_wdata;
    assign cpu_reg_rdata = s.reg_rdata;
    assign cpu_mem_rdata = s.mem_rdata;
    assign hp_irq = s.hp;
    assign std_level = s.lvl;
    assign std_pulse_b = s.pls_b;
endmodule
`default_nettype wire

// File: tb/mdil_link_assertions.sv
// Concurrent checks on the link between the two logger ends.
`timescale 1ns/1ps
`default_nettype none
module mdil_link_assertions (
    input wire logic mclk, // Clock.
    input wire logic rst_b, // Reset.
    input wire logic dma_req, // Request.
    input wire logic dma_burst, // Burst.
    input wire logic dma_grant, // Grant.
    input wire logic mem_strobe, // Access.
    input wire logic mem_we, // Write.
    input wire logic [mdil_pkg::DATA_W-1:0] mem_wdata, // Data.
    input wire logic mem_ack, // Done.
    input wire logic std_irq_level, // Level.
    input wire logic std_irq_pulse_b // Pulse.
);
    import mdil_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_first; $rose(dma_grant) && dma_burst |=> mem_strobe && mem_wdata[15]; endproperty
    a_first: assert property (p_first) else $error("flag low");
    property p_cause; $fell(std_irq_pulse_b) |-> $past(mem_ack && !mem_we && dma_burst); endproperty
    a_cause: assert property (p_cause) else $error("early pulse");
    property p_one; !std_irq_pulse_b |=> std_irq_pulse_b; endproperty
    a_one: assert property (p_one) else $error("long pulse");
    property p_cont; mem_ack && mem_we && dma_burst |=> mem_strobe; endproperty
    a_cont: assert property (p_cont) else $error("burst cut");
    property p_grant; mem_strobe |-> dma_grant && dma_req; endproperty
    a_grant: assert property (p_grant) else $error("no grant");
    property p_held; mem_strobe && !mem_ack |=> mem_strobe; endproperty
    a_held: assert property (p_held) else $error("strobe lost");
    property p_level; $rose(std_irq_level) |-> !std_irq_pulse_b; endproperty
    a_level: assert property (p_level) else $error("level alone");
    property p_end; $fell(dma_req) |-> $past(mem_ack); endproperty
    a_end: assert property (p_end) else $error("req dropped");
endmodule
`default_nettype wire

// File: tb/monitor_dma_interrupt_logger_tb_top.sv
// Bench joining the logger device end to the host end.
`timescale 1ns/1ps
`default_nettype none
module monitor_dma_interrupt_logger_tb_top;
    import mdil_pkg::*;
    logic mclk = 0, rst_b = 0, ev = 0, dl = 0, dv = 0, sv = 0, cv = 0, rw = 0, rr = 0, mw = 0;
    logic hold, hp, lv, pb;
    int pulses = 0;
    logic [15:0] a = 0, d = 0, rq, mq;
    int error_cnt = 0, cmp_count = 0;
    mdil_mode_type mode = MDIL_MODE_BC;
    mdil_link_if link ();
    always #12.5 mclk = ~mclk;
    mdil_device_end mdil_device_end_i (.mclk(mclk), .rst_b(rst_b), .link(link), .mode(mode),
        .evt_valid(ev), .evt_cause(d), .evt_ptr(a), .evt_ready(), .mon_dlp_load(dl), .mon_dlp(a),
        .mon_data_valid(dv), .mon_data(d), .mon_data_ready(), .mon_stat_valid(sv),
        .mon_stat_sel(1'b0), .mon_stat(d), .mon_stat_ready(), .mon_done_valid(cv), .mon_ctrl(d),
        .mon_done_ready(), .hold(hold));
    mdil_host_end mdil_host_end_i (.mclk(mclk), .rst_b(rst_b), .link(link), .cpu_reg_wr(rw),
        .cpu_reg_rd(rr), .cpu_reg_idx(a[4:0]), .cpu_reg_wdata(d), .cpu_reg_rdata(rq),
        .cpu_mem_wr(mw), .cpu_mem_addr(a), .cpu_mem_wdata(d), .cpu_mem_rdata(mq), .hp_irq(hp),
        .std_level(lv), .std_pulse_b(pb));
    // Counts low cycles of the host's copy of the standard pulse.
    always @(posedge mclk) begin
        if (rst_b && pb === 1'b0) begin
            pulses++;
        end
    end
    mdil_link_assertions mdil_link_assertions_i (.mclk(mclk), .rst_b(rst_b),
        .dma_req(link.dma_req), .dma_burst(link.dma_burst), .dma_grant(link.dma_grant),
        .mem_strobe(link.mem_strobe), .mem_we(link.mem_we), .mem_wdata(link.mem_wdata),
        .mem_ack(link.mem_ack), .std_irq_level(link.std_irq_level),
        .std_irq_pulse_b(link.std_irq_pulse_b));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One write pulse; m picks host memory over a register.
    task automatic put(input logic m, input logic [15:0] ad, input logic [15:0] v);
        @(posedge mclk);
        a <= ad;
        d <= v;
        mw <= m;
        rw <= !m;
        @(posedge mclk);
        mw <= 1'b0;
        rw <= 1'b0;
    endtask
    // Register reads answer two cycles after the request is taken.
    task automatic get(input logic m, input logic [15:0] ad, input logic [15:0] exp);
        @(posedge mclk);
        a <= ad;
        rr <= !m;
        @(posedge mclk);
        rr <= 1'b0;
        repeat (m ? 0 : 3) @(posedge mclk);
        #1 chk(m ? mq : rq, exp);
    endtask
    // The log burst finishes nine cycles after the event is taken.
    task automatic evt(input logic [15:0] c);
        @(posedge mclk);
        d <= c;
        a <= 16'h1234;
        ev <= 1'b1;
        @(posedge mclk);
        ev <= 1'b0;
        repeat (12) @(posedge mclk);
        #1;
    endtask
    task automatic t_log();
        put(0, 6, 16'h0040);
        put(0, 7, 16'h0003);
        put(0, 9, 16'hffff);
        put(1, 16'h0042, 16'h0060);
        evt(16'h000a);
        chk({13'h0, hold, hp, lv}, 16'h0007);
        chk(16'(pulses), 16'h0001);
        get(1, 16'h0040, 16'h800a);
        get(1, 16'h0041, 16'h1234);
        get(0, 6, 16'h0060);
        get(0, 8, 16'h0003);
        put(0, 8, 16'h0003);
        repeat (6) @(posedge mclk);
        #1 chk({13'h0, hold, hp, lv}, 16'h0000);
        @(posedge mclk);
        mode <= MDIL_MODE_RT;
        evt(16'h0108);
        get(0, 6, 16'h0060);
        chk(16'(pulses), 16'h0001);
        $display("t_log over");
    endtask
    task automatic t_mon();
        put(0, 5, 16'h00a0);
        put(1, 16'h00a6, 16'h00c0);
        @(posedge mclk);
        mode <= MDIL_MODE_MON;
        a <= 16'h0080;
        dl <= 1'b1;
        d <= 16'h1111;
        dv <= 1'b1;
        @(posedge mclk);
        dl <= 1'b0;
        d <= 16'h2222;
        @(posedge mclk);
        dv <= 1'b0;
        d <= 16'h3333;
        sv <= 1'b1;
        @(posedge mclk);
        sv <= 1'b0;
        d <= 16'h0042;
        cv <= 1'b1;
        @(posedge mclk);
        cv <= 1'b0;
        repeat (40) @(posedge mclk);
        get(1, 16'h0081, 16'h2222);
        get(1, 16'h00a4, 16'h3333);
        get(1, 16'h00a0, 16'h8042);
        get(0, 5, 16'h00c0);
        $display("t_mon over");
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #60000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        t_log();
        t_mon();
        wrap_up();
    end
endmodule
`default_nettype wire
